/* hdl/bandwidth_usage_monitor.v */
// Function
// - Instance count is a parameter-free constant, never above 65536.
// - Filtering uses the partition ID carried by the request itself.
// - Instance index in select register routes all monitor register accesses.
// - Resource selector must be 0 to reach these top-level monitors.
// - Enabled monitors add payload bytes of matching reads and writes.
// - Filter holds read/write match, partition ID and monitoring group.
// - Long 44-bit count register per instance, with not-ready flag.
// - Capture event copies count to snapshot, optionally clears count.
// - Long and capture both supported, so long snapshot exists.
// - Writing filter or control sets the not-ready flag.
// - Each capture event clears the not-ready flag; a same-cycle write to its registers, except long count low, overrides it.
// - Snapshot takes the not-ready flag before capture clears it.
// - Capture source field in control selects the event source.
// - Local trigger present; writing fire value emits local event.
// - Nonzero overflow link field signals that event on count overflow.
// - Scale enable 0 counts bytes, 1 counts scaled bytes in the short count; the long count always counts bytes.
// - Scaled count is byte count shifted right by fixed scale.
// - Short count value field is always 31 bits.
// - Software count write loads value and not-ready flag, anytime.
// - Disabled monitor never counts, but its capture event still updates snapshot, not-ready flag and, with clear, the count.
// - Config changes keep the count value.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "bw_monitor_regs.vh"

module bandwidth_usage_monitor (
  input wire I_CLK,
  input wire I_RESETN,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  input wire I_XFER_VALID,
  input wire I_XFER_WRITE,
  input wire [15:0] I_XFER_REQ_PARTITION_ID,
  input wire [7:0] I_XFER_PMG,
  input wire [7:0] I_XFER_BYTES,
  input wire [6:0] I_CAPT_EVENT,
  output reg [15:0] O_LINK_EVENT
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a <= `OFS_LSNAP_HI);
    end
  endfunction

  function is_inst_reg;
    input [7:0] a;
    begin
      is_inst_reg = (a >= `OFS_BW_CTL) && (a <= `OFS_LSNAP_HI);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  reg [15:0] sel_idx;
  reg [3:0] sel_ris;
  reg [31:0] ctl [0:`NUM_INST-1];
  reg [31:0] flt [0:`NUM_INST-1];
  reg [30:0] cnt [0:`NUM_INST-1];
  reg not_ready_flag [0:`NUM_INST-1];
  reg [`SCALE_SHIFT-1:0] frac [0:`NUM_INST-1];
  reg [`LONG_W-1:0] lcnt [0:`NUM_INST-1];
  reg [31:0] snap [0:`NUM_INST-1];
  reg [`LONG_W:0] lsnap [0:`NUM_INST-1];
  reg local_evt;

  wire bus_commit;
  wire bus_wr;
  wire sel_ok;
  wire [`INST_IDX_W-1:0] idx;
  wire [15:0] evt_vec;
  wire [15:0] link_acc [0:`NUM_INST];
  reg [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: two-cycle access phase, data and error registered

  // Write lands at the edge where the master sees pready high
  assign bus_commit = I_PSEL & I_PENABLE & O_PREADY;
  assign bus_wr = bus_commit & I_PWRITE & is_mapped(I_PADDR);

  // Unreachable selections read zero and drop writes
  assign sel_ok = (sel_ris == `TOP_LEVEL_RIS) && (sel_idx < `NUM_INST);
  assign idx = sel_idx[`INST_IDX_W-1:0];

  always @* begin
    rd_mux = 32'h00000000;
    case (I_PADDR)
      `OFS_INSTANCE_INDEX: rd_mux = {4'h0, sel_ris, 8'h00, sel_idx};
      `OFS_BW_ID: rd_mux = `ID_VALUE;
      `OFS_FEAT_ID: rd_mux = `FEAT_VALUE;
      default: begin
        if (sel_ok) begin
          case (I_PADDR)
            `OFS_BW_CTL: rd_mux = ctl[idx];
            `OFS_BW_FLT: rd_mux = flt[idx];
            `OFS_COUNT: rd_mux = {not_ready_flag[idx], cnt[idx]};
            `OFS_SNAP: rd_mux = snap[idx];
            `OFS_LONG_LO: rd_mux = lcnt[idx][31:0];
            `OFS_LONG_HI: rd_mux = {not_ready_flag[idx], 19'h00000, lcnt[idx][`LONG_W-1:32]};
            `OFS_LSNAP_LO: rd_mux = lsnap[idx][31:0];
            `OFS_LSNAP_HI: rd_mux = {lsnap[idx][`LONG_W], 19'h00000,
                                     lsnap[idx][`LONG_W-1:32]};
            default: rd_mux = 32'h00000000;
          endcase
        end
      end
    endcase
  end

  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else if (I_PSEL & I_PENABLE & ~O_PREADY) begin
      O_PREADY <= 1'b1;
      O_PRDATA <= I_PWRITE ? 32'h00000000 : rd_mux;
      O_PSLVERR <= ~is_mapped(I_PADDR);
    end else begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select register and local trigger

  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sel_idx <= 16'h0000;
      sel_ris <= 4'h0;
      local_evt <= 1'b0;
    end else begin
      local_evt <= 1'b0;
      if (bus_wr && I_PADDR == `OFS_INSTANCE_INDEX) begin
        sel_idx <= I_PWDATA[`SEL_IDX_MSB:`SEL_IDX_LSB];
        sel_ris <= I_PWDATA[`SEL_RIS_MSB:`SEL_RIS_LSB];
      end
      if (bus_wr && I_PADDR == `OFS_LOCAL_TRIG && I_PWDATA == `LOCAL_TRIG_FIRE) begin
        local_evt <= 1'b1;
      end
    end
  end

  // Linked overflow events reach capture logic one cycle later
  assign evt_vec = O_LINK_EVENT |
                   {7'h00, local_evt, I_CAPT_EVENT, 1'b0};

  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_LINK_EVENT <= 16'h0000;
    end else begin
      O_LINK_EVENT <= link_acc[`NUM_INST];
    end
  end

  assign link_acc[0] = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Per-instance counting, capture and register writes

  genvar g;
  generate
    for (g = 0; g < `NUM_INST; g = g + 1) begin : inst
      wire here;
      wire match;
      wire count_on;
      wire capture;
      wire scaled;
      wire [3:0] lnkg;
      wire [`SCALE_SHIFT+8:0] scale_sum;
      wire [31:0] short_inc;
      wire [31:0] short_sum;
      wire [`LONG_W:0] long_sum;
      wire ovfl;
      wire [15:0] own_link;

      assign here = sel_ok && (idx == g);
      // Request partition ID, never a narrowed one
      assign match = I_XFER_VALID &&
                     (I_XFER_WRITE ? flt[g][`FLT_WR_BIT] : flt[g][`FLT_RD_BIT]) &&
                     (I_XFER_REQ_PARTITION_ID == flt[g][`FLT_PARTITION_ID_MSB:`FLT_PARTITION_ID_LSB]) &&
                     (I_XFER_PMG == flt[g][`FLT_PMG_MSB:`FLT_PMG_LSB]);
      assign count_on = match & ctl[g][`CTL_EN_BIT];
      assign capture = evt_vec[ctl[g][`CTL_CAPT_MSB:`CTL_CAPT_LSB]];
      assign scaled = ctl[g][`CTL_SCALE_ENABLE_BIT];
      assign lnkg = ctl[g][`CTL_LNKG_MSB:`CTL_LNKG_LSB];

      // Residue keeps sub-unit bytes so scaling never loses them
      assign scale_sum = {1'b0, I_XFER_BYTES} + {9'h000, frac[g]};
      assign short_inc = scaled ?
                         {{(32 - 9){1'b0}}, scale_sum[`SCALE_SHIFT+8:`SCALE_SHIFT]} :
                         {24'h000000, I_XFER_BYTES};
      assign short_sum = {1'b0, cnt[g]} + short_inc;
      assign long_sum = {1'b0, lcnt[g]} + {{(`LONG_W - 7){1'b0}}, I_XFER_BYTES};
      assign ovfl = count_on & (short_sum[31] | long_sum[`LONG_W]);
      assign own_link = (ovfl && lnkg != 4'h0) ? (16'h0001 << lnkg) : 16'h0000;
      assign link_acc[g+1] = link_acc[g] | own_link;

      always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          ctl[g] <= 32'h00000000;
          flt[g] <= 32'h00000000;
          cnt[g] <= 31'h00000000;
          not_ready_flag[g] <= 1'b0;
          frac[g] <= {`SCALE_SHIFT{1'b0}};
          lcnt[g] <= {`LONG_W{1'b0}};
          snap[g] <= 32'h00000000;
          lsnap[g] <= {(`LONG_W + 1){1'b0}};
        end else begin
          if (count_on) begin
            cnt[g] <= short_sum[30:0];
            lcnt[g] <= long_sum[`LONG_W-1:0]; // Long count is never scaled
            if (scaled) begin
              frac[g] <= scale_sum[`SCALE_SHIFT-1:0];
            end
          end
          if (capture) begin
            snap[g] <= {not_ready_flag[g], cnt[g]};
            lsnap[g] <= {not_ready_flag[g], lcnt[g]};
            not_ready_flag[g] <= 1'b0;
            if (ctl[g][`CTL_CLR_ON_CAPT_BIT]) begin
              cnt[g] <= 31'h00000000;
              lcnt[g] <= {`LONG_W{1'b0}};
              frac[g] <= {`SCALE_SHIFT{1'b0}};
            end
          end
          if (bus_wr && here && is_inst_reg(I_PADDR)) begin
            case (I_PADDR)
              `OFS_BW_CTL: begin
                ctl[g] <= I_PWDATA & `CTL_WMASK;
                not_ready_flag[g] <= 1'b1;
              end
              `OFS_BW_FLT: begin
                flt[g] <= I_PWDATA;
                not_ready_flag[g] <= 1'b1;
              end
              `OFS_COUNT: begin
                cnt[g] <= I_PWDATA[30:0];
                not_ready_flag[g] <= I_PWDATA[31];
              end
              `OFS_LONG_LO: begin
                lcnt[g][31:0] <= I_PWDATA;
              end
              `OFS_LONG_HI: begin
                lcnt[g][`LONG_W-1:32] <= I_PWDATA[`LONG_W-33:0];
                not_ready_flag[g] <= I_PWDATA[31];
              end
              default: begin
                not_ready_flag[g] <= not_ready_flag[g];
              end
            endcase
          end
        end
      end
    end
  endgenerate

endmodule

/* hdl/bw_monitor_regs.vh */
`ifndef BW_MONITOR_REGS_VH
`define BW_MONITOR_REGS_VH

// Instance count, at most 65536 per monitor type
`define NUM_INST 4
`define INST_IDX_W 2

// Register byte offsets
`define OFS_INSTANCE_INDEX 8'h00
`define OFS_BW_ID 8'h04
`define OFS_FEAT_ID 8'h08
`define OFS_LOCAL_TRIG 8'h0C
`define OFS_BW_CTL 8'h10
`define OFS_BW_FLT 8'h14
`define OFS_COUNT 8'h18
`define OFS_SNAP 8'h1C
`define OFS_LONG_LO 8'h20
`define OFS_LONG_HI 8'h24
`define OFS_LSNAP_LO 8'h28
`define OFS_LSNAP_HI 8'h2C

// monitor_select_reg fields
`define SEL_IDX_LSB 0
`define SEL_IDX_MSB 15
`define SEL_RIS_LSB 24
`define SEL_RIS_MSB 27
`define TOP_LEVEL_RIS 4'h0

// bw_monitor_control fields
`define CTL_CAPT_LSB 8
`define CTL_CAPT_MSB 11
`define CTL_SCALE_ENABLE_BIT 12
`define CTL_LNKG_LSB 16
`define CTL_LNKG_MSB 19
`define CTL_CLR_ON_CAPT_BIT 24
`define CTL_EN_BIT 31
`define CTL_WMASK 32'h810F1F00

// bw_monitor_filter fields
`define FLT_PARTITION_ID_LSB 0
`define FLT_PARTITION_ID_MSB 15
`define FLT_PMG_LSB 16
`define FLT_PMG_MSB 23
`define FLT_RD_BIT 30
`define FLT_WR_BIT 31

// Scale shift, long count width and identification values
`define SCALE_SHIFT 3
`define LONG_W 44
`define ID_VALUE 32'hC0000003
`define FEAT_VALUE 32'h00000001

// Event numbering: 0 none, 1..7 external, 8 local trigger
`define NUM_EXT_EVT 7
`define LOCAL_EVT_NUM 8
`define LOCAL_TRIG_FIRE 32'h00000001

`endif

/* dv/xfer_src.sv */
`timescale 1ns/100ps
module xfer_src (
  input wire i_clk,
  output logic o_valid,
  output logic o_write,
  output logic [15:0] o_partition_id,
  output logic [7:0] o_pmg,
  output logic [7:0] o_bytes
);
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_partition_id = 16'h0000;
    o_pmg = 8'h00;
    o_bytes = 8'h00;
  end
  // One single-cycle valid pulse per call; fields scrambled once the pulse is over
  task send(input bit w, input [15:0] p, input [7:0] g, input [7:0] b);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_write <= w;
    o_partition_id <= p;
    o_pmg <= g;
    o_bytes <= b;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_write <= !w;
    o_partition_id <= ~p;
    o_pmg <= ~g;
    o_bytes <= ~b;
  endtask
endmodule

/* dv/bw_monitor_chk.sv */
`timescale 1ns/100ps
`include "bw_monitor_regs.vh"
module bw_monitor_chk (
  input wire I_CLK,
  input wire I_RESETN,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  input wire O_PSLVERR,
  input wire [15:0] O_LINK_EVENT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  property p_ready_next;
    I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("ready late");
  property p_ready_cause;
    O_PREADY |-> $past(I_PSEL && I_PENABLE) ##1 !O_PREADY;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
  property p_err_with_ready;
    O_PSLVERR |-> O_PREADY;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("lone error");
  property p_idle_data;
    !O_PREADY |-> O_PRDATA == 32'h00000000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("data while idle");
  property p_id_value;
    O_PREADY && $past(!I_PWRITE && I_PADDR == `OFS_BW_ID) |-> O_PRDATA == `ID_VALUE;
  endproperty
  a_id_value: assert property (p_id_value) else $error("id value");
  property p_unmapped;
    O_PREADY && $past(I_PADDR[1:0] != 2'h0 || I_PADDR > `OFS_LSNAP_HI) |-> O_PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_mapped;
    O_PREADY && $past(I_PADDR[1:0] == 2'h0 && I_PADDR <= `OFS_LSNAP_HI) |-> !O_PSLVERR;
  endproperty
  a_mapped: assert property (p_mapped) else $error("false error");
  property p_link0_quiet;
    !O_LINK_EVENT[0];
  endproperty
  a_link0_quiet: assert property (p_link0_quiet) else $error("link zero fired");
  property p_trig_reads_zero;
    O_PREADY && $past(!I_PWRITE && I_PADDR == `OFS_LOCAL_TRIG) |-> O_PRDATA == 32'h00000000;
  endproperty
  a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger read");
  c_write: cover property (O_PREADY && $past(I_PWRITE));
  c_error: cover property (O_PSLVERR);
  c_id: cover property (O_PREADY && $past(I_PADDR == `OFS_BW_ID));
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
`include "bw_monitor_regs.vh"
module testbench;
  logic I_CLK = 1'b0, I_RESETN = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h00000000, prd, rdat;
  logic [6:0] capt = 7'h00;
  logic xv, xw, ready, slverr;
  logic [15:0] xp, link;
  logic [7:0] xg, xb;
  int fails = 0, samples_checked = 0, link_seen = 0;
  logic [15:0] link_last = 16'h0000;
  localparam logic [31:0] EN = 32'h80000000;
  initial forever #5 I_CLK = ~I_CLK;
  // Every overflow pulse on the link output is counted, whichever bit
  always @(posedge I_CLK) begin
    if (link !== 16'h0000) begin
      link_seen++;
      link_last = link;
    end
  end
  xfer_src u_src (.i_clk(I_CLK), .o_valid(xv), .o_write(xw), .o_partition_id(xp), .o_pmg(xg),
    .o_bytes(xb));
  bandwidth_usage_monitor u_dut (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prd),
    .O_PREADY(ready), .O_PSLVERR(slverr), .I_XFER_VALID(xv), .I_XFER_WRITE(xw),
    .I_XFER_REQ_PARTITION_ID(xp), .I_XFER_PMG(xg), .I_XFER_BYTES(xb), .I_CAPT_EVENT(capt),
    .O_LINK_EVENT(link));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Request held until the edge that samples ready high
  task apb(input bit w, input [7:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge I_CLK);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge I_CLK);
    pen <= 1'b1;
    do begin
      @(posedge I_CLK);
      n++;
    end while (ready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "apb hang");
    rdat = prd;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, "read");
  endtask
  task pulse(input [6:0] v);
    @(posedge I_CLK);
    capt <= v;
    @(posedge I_CLK);
    capt <= 7'h00;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_count;
    rd(`OFS_BW_ID, `ID_VALUE);
    rd(`OFS_FEAT_ID, `FEAT_VALUE);
    wr(`OFS_INSTANCE_INDEX, 32'h0);
    wr(`OFS_BW_FLT, 32'h80020005);
    wr(`OFS_BW_CTL, EN);
    u_src.send(1, 16'h5, 8'h2, 8'h10);
    u_src.send(0, 16'h5, 8'h2, 8'h08);
    u_src.send(1, 16'h6, 8'h2, 8'h20);
    u_src.send(1, 16'h5, 8'h3, 8'h04);
    rd(`OFS_COUNT, 32'h80000010);
    rd(`OFS_LONG_LO, 32'h00000010);
    rd(`OFS_LONG_HI, 32'h80000000);
    $display("count test done");
  endtask
  task t_capture;
    wr(`OFS_BW_CTL, EN | 32'h01000100);
    pulse(7'h02);
    rd(`OFS_SNAP, 32'h0);
    pulse(7'h01);
    rd(`OFS_SNAP, 32'h80000010);
    rd(`OFS_COUNT, 32'h0);
    $display("capture test done");
  endtask
  task t_local;
    wr(`OFS_COUNT, 32'h00000123);
    wr(`OFS_BW_CTL, EN | 32'h00000800);
    rd(`OFS_COUNT, 32'h80000123);
    wr(`OFS_LOCAL_TRIG, `LOCAL_TRIG_FIRE);
    rd(`OFS_SNAP, 32'h80000123);
    rd(`OFS_COUNT, 32'h00000123);
    $display("local trigger test done");
  endtask
  task t_scale;
    wr(`OFS_BW_CTL, EN | 32'h00001000);
    wr(`OFS_COUNT, 32'h0);
    u_src.send(1, 16'h5, 8'h2, 8'd20);
    u_src.send(1, 16'h5, 8'h2, 8'd5);
    rd(`OFS_COUNT, 32'd25 >> `SCALE_SHIFT);
    wr(`OFS_BW_CTL, 32'h0);
    wr(`OFS_COUNT, 32'h7FFFFFFF);
    u_src.send(1, 16'h5, 8'h2, 8'd9);
    rd(`OFS_COUNT, 32'h7FFFFFFF);
    chk(link_seen, 32'h0, "early link");
    // Link 9 feeds back as capture source 9, so the wrap is captured
    wr(`OFS_BW_CTL, EN | 32'h00090900);
    u_src.send(1, 16'h5, 8'h2, 8'd9);
    rd(`OFS_SNAP, 32'h80000008);
    rd(`OFS_COUNT, 32'h00000008);
    chk(link_seen, 32'h1, "link pulses");
    chk({16'h0000, link_last}, 32'h00000200, "link bit");
    $display("scale test done");
  endtask
  task t_select;
    wr(`OFS_INSTANCE_INDEX, 32'h1);
    rd(`OFS_BW_CTL, 32'h0);
    wr(`OFS_INSTANCE_INDEX, 32'h01000000);
    rd(`OFS_COUNT, 32'h0);
    rd(`OFS_LOCAL_TRIG, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    $display("select test done");
  endtask
  task final_report;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    t_count;
    t_capture;
    t_local;
    t_scale;
    t_select;
    final_report;
  end
  initial begin
    #100000;
    fails++;
    final_report;
  end
endmodule
bind bandwidth_usage_monitor bw_monitor_chk u_chk (.*);
